// ===== src/vbi_slicer_pkg.sv
// constants, register map and carrier types of the vbi byte slicer
// assumes one 25 mhz sample clock shared by all users of the package
package vbi_slicer_pkg;

  // ==========================================================
  // register offsets
  localparam logic [7:0] off_corrected_byte_counter = 8'hb3;
  localparam logic [7:0] off_filter_coefficient_readback = 8'hb6;
  localparam logic [7:0] off_slicer_level_readback = 8'hb7;
  localparam logic [7:0] off_framing_mask_high = 8'hb8;
  localparam logic [7:0] off_framing_mask_mid = 8'hb9;
  localparam logic [7:0] off_framing_mask_low = 8'hba;
  localparam logic [7:0] off_framing_reference_high = 8'hbb;
  localparam logic [7:0] off_framing_reference_mid = 8'hbc;
  localparam logic [7:0] off_framing_reference_low = 8'hbd;
  localparam logic [7:0] off_adaption_control = 8'hc7;
  localparam logic [7:0] off_service_select = 8'hc9;
  localparam logic [7:0] off_bit_error_limits = 8'hce;
  localparam logic [7:0] off_line_output_control = 8'hcf;

  // ==========================================================
  // reset values
  localparam logic [7:0] rst_framing_mask = 8'h00;
  localparam logic [7:0] rst_framing_reference_high = 8'h27;
  localparam logic [7:0] rst_framing_reference_mid = 8'h55;
  localparam logic [7:0] rst_framing_reference_low = 8'h55;
  localparam logic [7:0] rst_adaption_control = 8'h30;
  localparam logic [7:0] rst_service_select = 8'h19;
  localparam logic [7:0] rst_bit_error_limits = 8'h15;
  localparam logic [7:0] rst_line_output_control = 8'h6b;

  // ==========================================================
  // field positions
  localparam int ac_adapt_bit = 4;
  localparam int flt_adapt_bit = 5;
  localparam int teletext_bit = 0;
  localparam int timing_525_bit = 1;
  localparam int full_field_bit = 2;
  localparam int line16_bit = 3;
  localparam int line23_bit = 4;
  localparam int line21_first_field_enable_bit = 5;
  localparam int line21_second_field_enable_bit = 6;
  localparam int quit_disable_bit = 7;
  localparam int fixed_64_byte_format_bit = 6;
  localparam int every_line_bit = 7;

  // ==========================================================
  // sizes and counts
  localparam int pattern_bits = 24;
  localparam logic [6:0] fixed_line_bytes = 7'h40;
  localparam logic [9:0] line_16 = 10'h010;
  localparam logic [9:0] line_21 = 10'h015;
  localparam logic [9:0] line_23 = 10'h017;
  localparam logic [7:0] counter_max = 8'hff;
  localparam int fifo_width = 9;
  localparam int fifo_depth = 16;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic valid;
    logic data;
  } sliced_bit_t;

  typedef struct packed {
    logic start;
    logic second_field;
    logic blanking;
    logic [9:0] number;
  } line_info_t;

  typedef struct packed {
    logic first;
    logic [7:0] data;
  } line_byte_t;

endpackage : vbi_slicer_pkg

// ===== src/vbi_byte_fifo.sv
// small first-in first-out buffer with valid and ready on both sides
// assumes the writer only pushes while o_in_ready is high
module vbi_byte_fifo #(
  parameter int width = 9,
  parameter int depth = 16
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_in_valid,
  input wire logic [width-1:0] i_in_data,
  output logic o_in_ready,
  output logic o_out_valid,
  output logic [width-1:0] o_out_data,
  input wire logic i_out_ready
);

  localparam int aw = $clog2(depth);

  logic [width-1:0] mem [depth];
  logic [aw-1:0] wr_ptr;
  logic [aw-1:0] rd_ptr;
  logic [aw:0] fill;
  logic push;
  logic pop;

  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  assign o_out_data = mem[rd_ptr];

  // ==========================================================
  // storage
  always_ff @(posedge i_clk) begin
    if (i_ce && push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  // ==========================================================
  // pointers and flags, registered so ready and valid are clean
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill <= '0;
      o_in_ready <= 1'b1;
      o_out_valid <= 1'b0;
    end else if (i_ce) begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      unique case ({push, pop})
        2'b10: begin
          fill <= fill + 1'b1;
          o_in_ready <= (fill + 1'b1) != (aw+1)'(depth);
          o_out_valid <= 1'b1;
        end
        2'b01: begin
          fill <= fill - 1'b1;
          o_in_ready <= 1'b1;
          o_out_valid <= fill != (aw+1)'(1);
        end
        default: begin
        end
      endcase
    end
  end

endmodule : vbi_byte_fifo

// ===== src/vbi_byte_slicer_framer.sv
// byte slicer and line framer of the vbi data slicer, with its registers
// assumes sliced bits and line info arrive synchronous to i_clk
module vbi_byte_slicer_framer (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_rvalid,
  input wire vbi_slicer_pkg::sliced_bit_t i_bit,
  output logic o_bit_ready,
  input wire vbi_slicer_pkg::line_info_t i_line,
  input wire logic i_soft_fix,
  input wire logic [7:0] i_slicer_level,
  input wire logic [7:0] i_filter_coeff,
  output logic o_ac_adapt_en,
  output logic o_flt_adapt_en,
  output logic o_timing_525,
  output logic o_quit_en,
  output vbi_slicer_pkg::line_byte_t o_byte,
  output logic o_byte_valid,
  input wire logic i_byte_ready
);

  typedef enum logic [1:0] {
    st_idle,
    st_hunt,
    st_data
  } line_state_t;

  // ==========================================================
  // register storage
  logic [7:0] mask_high;
  logic [7:0] mask_mid;
  logic [7:0] mask_low;
  logic [7:0] ref_high;
  logic [7:0] ref_mid;
  logic [7:0] ref_low;
  logic [7:0] adaption_control;
  logic [7:0] service_select;
  logic [7:0] bit_error_limits;
  logic [7:0] line_output_control;
  logic [7:0] corrected_byte_counter;
  logic [7:0] level_in_use;
  logic [7:0] coeff_in_use;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      mask_high <= vbi_slicer_pkg::rst_framing_mask;
      mask_mid <= vbi_slicer_pkg::rst_framing_mask;
      mask_low <= vbi_slicer_pkg::rst_framing_mask;
      ref_high <= vbi_slicer_pkg::rst_framing_reference_high;
      ref_mid <= vbi_slicer_pkg::rst_framing_reference_mid;
      ref_low <= vbi_slicer_pkg::rst_framing_reference_low;
      adaption_control <= vbi_slicer_pkg::rst_adaption_control;
      service_select <= vbi_slicer_pkg::rst_service_select;
      bit_error_limits <= vbi_slicer_pkg::rst_bit_error_limits;
      line_output_control <= vbi_slicer_pkg::rst_line_output_control;
    end else if (i_ce && i_reg_wr) begin
      unique case (i_reg_addr)
        vbi_slicer_pkg::off_framing_mask_high: mask_high <= i_reg_wdata;
        vbi_slicer_pkg::off_framing_mask_mid: mask_mid <= i_reg_wdata;
        vbi_slicer_pkg::off_framing_mask_low: mask_low <= i_reg_wdata;
        vbi_slicer_pkg::off_framing_reference_high: ref_high <= i_reg_wdata;
        vbi_slicer_pkg::off_framing_reference_mid: ref_mid <= i_reg_wdata;
        vbi_slicer_pkg::off_framing_reference_low: ref_low <= i_reg_wdata;
        vbi_slicer_pkg::off_adaption_control: adaption_control <= i_reg_wdata;
        vbi_slicer_pkg::off_service_select: service_select <= i_reg_wdata;
        vbi_slicer_pkg::off_bit_error_limits: bit_error_limits <= i_reg_wdata;
        vbi_slicer_pkg::off_line_output_control: line_output_control <= i_reg_wdata;
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // control outputs taken from the control bytes, quit enable as the inverse of its bit
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_ac_adapt_en <= 1'b0;
      o_flt_adapt_en <= 1'b0;
      o_timing_525 <= 1'b0;
      o_quit_en <= 1'b0;
    end else if (i_ce) begin
      o_ac_adapt_en <= adaption_control[vbi_slicer_pkg::ac_adapt_bit];
      o_flt_adapt_en <= adaption_control[vbi_slicer_pkg::flt_adapt_bit];
      o_timing_525 <= service_select[vbi_slicer_pkg::timing_525_bit];
      o_quit_en <= !service_select[vbi_slicer_pkg::quit_disable_bit];
    end
  end

  // ==========================================================
  // readback capture of the live slicer values
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      level_in_use <= 8'h00;
      coeff_in_use <= 8'h00;
    end else if (i_ce) begin
      level_in_use <= i_slicer_level;
      coeff_in_use <= i_filter_coeff;
    end
  end

  // ==========================================================
  // register read port, write-only and unmapped read as zero
  logic counter_read;

  assign counter_read = i_reg_rd && (i_reg_addr == vbi_slicer_pkg::off_corrected_byte_counter);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_reg_rdata <= 8'h00;
      o_reg_rvalid <= 1'b0;
    end else if (i_ce) begin
      o_reg_rvalid <= i_reg_rd;
      if (i_reg_rd) begin
        unique case (i_reg_addr)
          vbi_slicer_pkg::off_corrected_byte_counter: o_reg_rdata <= corrected_byte_counter;
          vbi_slicer_pkg::off_filter_coefficient_readback: o_reg_rdata <= coeff_in_use;
          vbi_slicer_pkg::off_slicer_level_readback: o_reg_rdata <= level_in_use;
          default: o_reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // ==========================================================
  // corrected byte counter; a fix in the read cycle survives as one
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      corrected_byte_counter <= 8'h00;
    end else if (i_ce) begin
      if (counter_read) begin
        corrected_byte_counter <= {7'h00, i_soft_fix};
      end else if (i_soft_fix && corrected_byte_counter != vbi_slicer_pkg::counter_max) begin
        corrected_byte_counter <= corrected_byte_counter + 8'h01;
      end
    end
  end

  // ==========================================================
  // line acceptance
  logic line_wanted;
  logic every_line;
  logic [6:0] line_bytes;

  assign every_line = line_output_control[vbi_slicer_pkg::every_line_bit];
  // fixed format overrides the programmed count
  assign line_bytes = line_output_control[vbi_slicer_pkg::fixed_64_byte_format_bit] ?
                      vbi_slicer_pkg::fixed_line_bytes :
                      {1'b0, line_output_control[5:0]};

  always_comb begin
    line_wanted = 1'b0;
    if (service_select[vbi_slicer_pkg::teletext_bit] &&
        (service_select[vbi_slicer_pkg::full_field_bit] || i_line.blanking)) begin
      line_wanted = 1'b1;
    end
    if (service_select[vbi_slicer_pkg::line16_bit] && i_line.number == vbi_slicer_pkg::line_16) begin
      line_wanted = 1'b1;
    end
    if (service_select[vbi_slicer_pkg::line23_bit] && i_line.number == vbi_slicer_pkg::line_23) begin
      line_wanted = 1'b1;
    end
    if (i_line.number == vbi_slicer_pkg::line_21) begin
      if (!i_line.second_field &&
          service_select[vbi_slicer_pkg::line21_first_field_enable_bit]) begin
        line_wanted = 1'b1;
      end
      if (i_line.second_field &&
          service_select[vbi_slicer_pkg::line21_second_field_enable_bit]) begin
        line_wanted = 1'b1;
      end
    end
  end

  // ==========================================================
  // framing comparison over the last 24 received bits
  logic [23:0] window;
  logic [23:0] next_window;
  logic [23:0] mismatch;
  logic [4:0] bits_seen;
  logic framing_ok;
  logic take_bit;

  function automatic logic [3:0] ones(input logic [7:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int k = 0; k < 8; k++) begin
      n = n + {3'h0, v[k]};
    end
    return n;
  endfunction : ones

  assign take_bit = i_bit.valid && o_bit_ready;
  // newest bit enters at the top so the first one ends in the lsb
  assign next_window = {i_bit.data, window[23:1]};
  assign mismatch = (next_window ^ {ref_high, ref_mid, ref_low}) &
                    ~{mask_high, mask_mid, mask_low};
  assign framing_ok = (bits_seen >= 5'(vbi_slicer_pkg::pattern_bits - 1)) &&
                      (ones(mismatch[7:0]) <= {2'b00, bit_error_limits[1:0]}) &&
                      (ones(mismatch[15:8]) <= {2'b00, bit_error_limits[3:2]}) &&
                      (ones(mismatch[23:16]) <= {2'b00, bit_error_limits[5:4]});

  // ==========================================================
  // line sequencer
  line_state_t state;
  logic [6:0] bytes_left;
  logic [2:0] bit_pos;
  logic [7:0] assembly;
  logic first_pending;
  logic push_valid;
  vbi_slicer_pkg::line_byte_t push_byte;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= st_idle;
      window <= 24'h000000;
      bits_seen <= 5'h00;
      bytes_left <= 7'h00;
      bit_pos <= 3'h0;
      assembly <= 8'h00;
      first_pending <= 1'b0;
      push_valid <= 1'b0;
      push_byte <= '0;
    end else if (i_ce) begin
      push_valid <= 1'b0;
      if (i_line.start) begin
        window <= 24'h000000;
        bits_seen <= 5'h00;
        bit_pos <= 3'h0;
        bytes_left <= line_bytes;
        first_pending <= 1'b1;
        if (line_bytes == 7'h00) begin
          state <= st_idle;
        end else if (every_line) begin
          state <= st_data;
        end else if (line_wanted) begin
          state <= st_hunt;
        end else begin
          state <= st_idle;
        end
      end else if (take_bit) begin
        window <= next_window;
        unique case (state)
          st_idle: begin
          end
          st_hunt: begin
            if (bits_seen != 5'h1f) begin
              bits_seen <= bits_seen + 5'h01;
            end
            if (framing_ok) begin
              // framing code byte is the first counted byte
              push_valid <= 1'b1;
              push_byte <= '{first: 1'b1, data: next_window[23:16]};
              first_pending <= 1'b0;
              bytes_left <= bytes_left - 7'h01;
              state <= (bytes_left == 7'h01) ? st_idle : st_data;
            end
          end
          st_data: begin
            assembly <= {i_bit.data, assembly[7:1]};
            bit_pos <= bit_pos + 3'h1;
            if (bit_pos == 3'h7) begin
              push_valid <= 1'b1;
              push_byte <= '{first: first_pending, data: {i_bit.data, assembly[7:1]}};
              first_pending <= 1'b0;
              bytes_left <= bytes_left - 7'h01;
              if (bytes_left == 7'h01) begin
                state <= st_idle;
              end
            end
          end
        endcase
      end
    end
  end

  // ==========================================================
  // output buffer; its ready stalls the bit source
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [vbi_slicer_pkg::fifo_width-1:0] fifo_out_data;

  vbi_byte_fifo #(
    .width(vbi_slicer_pkg::fifo_width),
    .depth(vbi_slicer_pkg::fifo_depth)
  ) u_fifo (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_in_valid(push_valid),
    .i_in_data(push_byte),
    .o_in_ready(fifo_in_ready),
    .o_out_valid(fifo_out_valid),
    .o_out_data(fifo_out_data),
    .i_out_ready(i_byte_ready)
  );

  // ==========================================================
  // bit source handshake
  // ready is a flop, so it drops for two cycles around each push:
  // the fifo's own ready is only known once the push has landed,
  // a little throughput traded for a clean registered output
  logic next_push;

  assign next_push = take_bit && !i_line.start &&
                     ((state == st_hunt && framing_ok) ||
                      (state == st_data && bit_pos == 3'h7));

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_bit_ready <= 1'b1;
    end else if (i_ce) begin
      o_bit_ready <= fifo_in_ready && !push_valid && !next_push;
    end
  end

  assign o_byte_valid = fifo_out_valid;
  assign o_byte = vbi_slicer_pkg::line_byte_t'(fifo_out_data);

endmodule : vbi_byte_slicer_framer

// ===== test/vbi_byte_slicer_framer_monitor.sv
// checker of the byte slicer framer ports
// assumes i_ce is high whenever a request is made
module vbi_framer_monitor (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [7:0] o_reg_rdata,
  input wire logic o_reg_rvalid,
  input wire logic i_soft_fix,
  input wire logic [7:0] i_slicer_level,
  input wire logic o_ac_adapt_en,
  input wire logic o_flt_adapt_en,
  input wire logic o_quit_en,
  input wire vbi_slicer_pkg::line_byte_t o_byte,
  input wire logic o_byte_valid,
  input wire logic i_byte_ready
);
  // ==========================================================
  // shadow of the written control bytes
  logic [7:0] adapt;
  logic [7:0] svc;
  logic [1:0] quiet;
  wire logic wr_ok = i_ce && i_reg_wr;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      adapt <= vbi_slicer_pkg::rst_adaption_control;
    end else if (wr_ok && i_reg_addr == 8'hc7) begin
      adapt <= i_reg_wdata;
    end
  end
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      svc <= vbi_slicer_pkg::rst_service_select;
    end else if (wr_ok && i_reg_addr == 8'hc9) begin
      svc <= i_reg_wdata;
    end
  end
  // outputs are registered, so two edges pass before they are judged
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      quiet <= 2'h0;
    end else if (wr_ok) begin
      quiet <= 2'h0;
    end else if (quiet != 2'h3) begin
      quiet <= quiet + 2'h1;
    end
  end
  // ==========================================================
  // properties
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  sequence s_cnt_read;
    i_ce && i_reg_rd && !i_soft_fix && i_reg_addr == 8'hb3;
  endsequence
  a_cnt_clears: assert property (s_cnt_read ##1 s_cnt_read |=> o_reg_rdata == 8'h00)
    else $error("counter not cleared by read");
  a_rvalid_timing: assert property (o_reg_rvalid == $past(i_ce && i_reg_rd))
    else $error("read valid out of step");
  a_level_read: assert property (i_ce && i_reg_rd && i_reg_addr == 8'hb7
    && $stable(i_slicer_level) |=> o_reg_rdata == $past(i_slicer_level, 2))
    else $error("level readback wrong");
  a_wo_reads_zero: assert property (i_ce && i_reg_rd && i_reg_addr >= 8'hb8
    && i_reg_addr <= 8'hbd |=> o_reg_rdata == 8'h00)
    else $error("write-only byte read back");
  a_ac_follow: assert property (quiet[1] |-> o_ac_adapt_en == adapt[4])
    else $error("ac adaption enable wrong");
  a_flt_follow: assert property (quiet[1] |-> o_flt_adapt_en == adapt[5])
    else $error("filter adaption enable wrong");
  a_quit_polarity: assert property (quiet[1] |-> o_quit_en == !svc[7])
    else $error("quit enable polarity wrong");
  a_byte_hold: assert property (i_ce && o_byte_valid && !i_byte_ready
    |=> o_byte_valid && $stable(o_byte))
    else $error("byte changed while stalled");
endmodule : vbi_framer_monitor

bind vbi_byte_slicer_framer vbi_framer_monitor mon_u (
  .i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
  .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
  .o_reg_rvalid(o_reg_rvalid), .i_soft_fix(i_soft_fix), .i_slicer_level(i_slicer_level),
  .o_ac_adapt_en(o_ac_adapt_en), .o_flt_adapt_en(o_flt_adapt_en), .o_quit_en(o_quit_en),
  .o_byte(o_byte), .o_byte_valid(o_byte_valid), .i_byte_ready(i_byte_ready)
);

// ===== test/vbi_bit_partner.sv
// far side model: bit slicer front end and text byte consumer
// assumes send is called just after a rising edge
module vbi_bit_partner (
  input wire logic i_clk,
  input wire logic i_bit_ready,
  input wire logic i_stall,
  output vbi_slicer_pkg::sliced_bit_t o_bit,
  output logic o_byte_ready,
  output logic o_timeout
);
  timeunit 1ns;
  timeprecision 1ps;
  assign o_byte_ready = !i_stall;
  initial begin
    o_bit = '0;
    o_timeout = 1'b0;
  end
  // ==========================================================
  // bits go first received first; each holds until ready seen high
  task automatic send(input logic bits[$]);
    logic r;
    int k;
    foreach (bits[i]) begin
      o_bit.valid = 1'b1;
      o_bit.data = bits[i];
      k = 0;
      do begin
        @(negedge i_clk);
        r = i_bit_ready;
        @(posedge i_clk);
        #1;
        k++;
      end while (r !== 1'b1 && k < 2000);
      if (k >= 2000) o_timeout = 1'b1;
    end
    o_bit.valid = 1'b0;
    // released line shows the inverse, never a stale value
    o_bit.data = ~o_bit.data;
  endtask : send
endmodule : vbi_bit_partner

// ===== test/tb_top.sv
// self-checking bench of the vbi byte slicer framer
// assumes the partner model and the bound checker are compiled alongside
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic fix = 1'b0;
  logic hold = 1'b0;
  logic stall = 1'b0;
  logic ce = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] level = 8'h40;
  logic [7:0] coeff = 8'h07;
  logic [7:0] rdata;
  logic rvalid, bit_ready, ac, flt, t525, quit, byte_valid, byte_ready, p_to;
  vbi_slicer_pkg::sliced_bit_t bit_in;
  vbi_slicer_pkg::line_info_t line = '0;
  vbi_slicer_pkg::line_byte_t byte_out;
  logic [9:0] svc_line[4] = '{10'h010, 10'h017, 10'h015, 10'h015};
  logic [31:0] seed = 32'h00007720;
  logic [8:0] exp_q[$];
  logic bq[$];
  int n_errors = 0;
  int check_count = 0;
  int cyc = 0;
  always #20 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    #1;
    cyc++;
    stall = hold || (cyc % 5 < 2);
  end
  vbi_byte_slicer_framer dut_u (
    .i_clk(i_clk), .i_rst(i_rst), .i_ce(ce), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
    .i_bit(bit_in), .o_bit_ready(bit_ready), .i_line(line), .i_soft_fix(fix),
    .i_slicer_level(level), .i_filter_coeff(coeff), .o_ac_adapt_en(ac),
    .o_flt_adapt_en(flt), .o_timing_525(t525), .o_quit_en(quit), .o_byte(byte_out),
    .o_byte_valid(byte_valid), .i_byte_ready(byte_ready));
  vbi_bit_partner partner_u (.i_clk(i_clk), .i_bit_ready(bit_ready), .i_stall(stall),
    .o_bit(bit_in), .o_byte_ready(byte_ready), .o_timeout(p_to));
  // ==========================================================
  // helpers
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction : rnd
  task automatic summarize();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize
  task automatic ck_reg(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", n, e, g);
      n_errors++;
    end
  endtask : ck_reg
  task automatic ck_byte(input string n, input logic [8:0] e, input logic [8:0] g);
    check_count++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", n, e, g);
      n_errors++;
    end
  endtask : ck_byte
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : tick
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    wr = 1'b1;
    addr = a;
    wdata = d;
    tick(1);
    wr = 1'b0;
    tick(1);
  endtask : wreg
  task automatic rreg(input logic [7:0] a, input logic [7:0] e);
    rd = 1'b1;
    addr = a;
    tick(1);
    rd = 1'b0;
    ck_reg("rvalid", 8'h01, {7'h00, rvalid});
    ck_reg("rdata", e, rdata);
    tick(1);
  endtask : rreg
  task automatic fixn(input int n);
    repeat (n) begin
      fix = 1'b1;
      tick(1);
      fix = 1'b0;
      tick(1);
    end
  endtask : fixn
  // nb expected bytes; framing byte is the top 8 received bits
  task automatic run_line(input logic blank, input logic [9:0] num, input logic sec,
      input logic [23:0] pat, input int nb, input logic dump);
    logic [7:0] b;
    int k;
    bq.delete();
    for (int i = 0; i < 24 && !dump; i++) bq.push_back(pat[i]);
    for (int j = 0; j < nb; j++) begin
      b = (j == 0 && !dump) ? pat[23:16] : rnd();
      exp_q.push_back({j == 0, b});
      if (j > 0 || dump) for (int i = 0; i < 8; i++) bq.push_back(b[i]);
    end
    line = {1'b1, sec, blank, num};
    tick(1);
    line.start = 1'b0;
    partner_u.send(bq);
    k = 0;
    while ((exp_q.size() != 0 || byte_valid !== 1'b0) && k < 3000) begin
      tick(1);
      k++;
    end
    if (k == 3000) begin
      n_errors++;
      summarize();
    end
    tick(20);
    ck_reg("bytes left", 8'h00, 8'(exp_q.size()));
    $display("done line %0d", num);
  endtask : run_line
  always @(negedge i_clk) begin
    if (!i_rst && byte_valid === 1'b1 && byte_ready === 1'b1) begin
      if (exp_q.size() == 0) begin
        $display("BAD extra byte expected none seen %h", byte_out);
        n_errors++;
      end else begin
        ck_byte("line byte", exp_q.pop_front(), byte_out);
      end
    end
  end
  always @(posedge p_to) begin
    n_errors++;
    summarize();
  end
  initial begin
    #4000000;
    n_errors++;
    summarize();
  end
  // ==========================================================
  // scenarios
  initial begin
    tick(4);
    i_rst = 1'b0;
    tick(2);
    ck_reg("ctl", 8'h0d, {4'h0, ac, flt, t525, quit});
    for (int i = 0; i < 4; i++) begin
      wreg(8'hc7, {2'b00, i[1], i[0], 4'h0});
      wreg(8'hc9, {i[0], 5'h00, i[1], 1'b1});
      tick(1);
      ck_reg("ctl", {4'h0, i[0], i[1], i[1], !i[0]}, {4'h0, ac, flt, t525, quit});
    end
    wreg(8'hc9, 8'h19);
    ce = 1'b0;
    wreg(8'hc7, 8'h00);
    ce = 1'b1;
    tick(1);
    ck_reg("frozen", 8'h0d, {4'h0, ac, flt, t525, quit});
    $display("done controls");
    for (int i = 0; i < 3; i++) begin
      level = rnd();
      coeff = rnd();
      tick(3);
      rreg(8'hb7, level);
      rreg(8'hb6, coeff);
    end
    rreg(8'hbb, 8'h00);
    rreg(8'hba, 8'h00);
    rreg(8'h00, 8'h00);
    fixn(300);
    rd = 1'b1;
    addr = 8'hb3;
    tick(1);
    ck_reg("cnt", 8'hff, rdata);
    tick(1);
    ck_reg("cnt", 8'h00, rdata);
    fix = 1'b1;
    tick(1);
    rd = 1'b0;
    fix = 1'b0;
    ck_reg("cnt", 8'h00, rdata);
    fixn(3);
    rreg(8'hb3, 8'h04);
    $display("done counter");
    wreg(8'hcf, 8'h05);
    run_line(1, 10'h00a, 0, 24'h275555, 5, 0);
    run_line(1, 10'h00a, 0, 24'h265455, 5, 0);
    run_line(1, 10'h00a, 0, 24'h275556, 0, 0);
    wreg(8'hce, 8'h2a);
    run_line(1, 10'h00a, 0, 24'h275556, 5, 0);
    wreg(8'hce, 8'h15);
    wreg(8'hba, 8'hff);
    run_line(1, 10'h00a, 0, 24'h2755aa, 5, 0);
    run_line(1, 10'h00a, 0, 24'h2756aa, 0, 0);
    wreg(8'hba, 8'h00);
    wreg(8'hbd, 8'h3c);
    wreg(8'hbc, 8'h96);
    wreg(8'hbb, 8'h5a);
    run_line(1, 10'h00a, 0, 24'h5a963c, 5, 0);
    run_line(1, 10'h00a, 0, 24'h275555, 0, 0);
    wreg(8'hcf, 8'h45);
    hold = 1'b1;
    fork
      run_line(1, 10'h00a, 0, 24'h5a963c, 64, 0);
      begin
        tick(300);
        ck_reg("bit_ready", 8'h00, {7'h00, bit_ready});
        hold = 1'b0;
      end
    join
    wreg(8'hcf, 8'h05);
    run_line(0, 10'h00a, 0, 24'h5a963c, 0, 0);
    wreg(8'hcf, 8'h83);
    run_line(0, 10'h00a, 0, 24'h000000, 3, 1);
    wreg(8'hcf, 8'h05);
    wreg(8'hc9, 8'h05);
    run_line(0, 10'h00a, 0, 24'h5a963c, 5, 0);
    wreg(8'hc9, 8'h18);
    run_line(1, 10'h00a, 0, 24'h5a963c, 0, 0);
    for (int i = 3; i < 7; i++) begin
      wreg(8'hc9, 8'(1 << i));
      run_line(0, svc_line[i - 3], i == 6, 24'h5a963c, 5, 0);
    end
    summarize();
  end
endmodule : tb_top
